//--- verilog/fhp_top.sv
`timescale 1ns/10ps
`include "fhp_map.svh"

module fhp_top #(
  parameter int STEP_UNIT_CYC = (`FHP_STEP_UNIT_NS + `FHP_CLK_PERIOD_NS - 1) / `FHP_CLK_PERIOD_NS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [3:0] trackZeroIn,
  input wire logic indexPulseIn,
  input wire logic idValid,
  input wire logic [7:0] idCyl,
  input wire logic [7:0] idHead,
  input wire logic [7:0] idSector,
  input wire logic [7:0] idSize,
  output logic [3:0] stepOut,
  output logic [3:0] dirOut,
  output logic fdcIrq
);

  fhp_pkg::fhp_top_regs_t r_reg;
  fhp_pkg::fhp_top_regs_t r_next;
  logic [3:0][7:0] presentCyl;
  logic [3:0] doneStrobe;
  logic [3:0] equipFault;
  logic [3:0] driveActive;

  function automatic logic [1:0] fhpLowest(input logic [3:0] pend);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (pend[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  // returns {fill byte, byte count}; data field length left to the sector size
  function automatic logic [15:0] fhpFmtField(input logic [3:0] idx, input logic [7:0] gapLen);
    logic [15:0] f;
    f = 16'h0000;
    unique case (idx)
      4'h0: f = 16'h4e50;
      4'h1: f = 16'h000c;
      4'h2: f = 16'hc203;
      4'h3: f = 16'h4e32;
      4'h4: f = 16'h000c;
      4'h5: f = 16'ha103;
      4'h6: f = 16'h0006;
      4'h7: f = 16'h4e16;
      4'h8: f = 16'h000c;
      4'h9: f = 16'ha103;
      4'ha: f = 16'h0000;
      4'hb: f = 16'h0002;
      4'hc: f = {8'h4e, gapLen};
      4'hd: f = 16'h4e00;
      default: f = 16'h0000;
    endcase
    return f;
  endfunction

  always_comb begin
    logic hit;
    logic [3:0] op;
    logic [1:0] drv;
    logic [1:0] pick;
    logic [15:0] fmt;
    hit = cyc_i & stb_i & ~r_reg.ack;
    op = dat_i[3:0];
    drv = dat_i[5:4];
    pick = fhpLowest(r_reg.intPend);
    fmt = fhpFmtField(r_reg.fmtIdx, r_reg.gap);
    r_next = r_reg;
    r_next.startSeek = 4'h0;
    r_next.startRecal = 4'h0;
    r_next.clearPos = 1'b0;

    // a change counts only once the second and third stages agree
    r_next.tzS1 = trackZeroIn;
    r_next.tzS2 = r_reg.tzS1;
    r_next.tzS3 = r_reg.tzS2;
    r_next.tzLvl = (~(r_reg.tzS2 ^ r_reg.tzS3) & r_reg.tzS3) | ((r_reg.tzS2 ^ r_reg.tzS3) & r_reg.tzLvl);
    r_next.ixS1 = indexPulseIn;
    r_next.ixS2 = r_reg.ixS1;
    r_next.ixS3 = r_reg.ixS2;
    if (r_reg.ixS2 == r_reg.ixS3) begin
      r_next.ixLvl = r_reg.ixS3;
    end

    r_next.ack = hit;
    if (hit && we_i) begin
      if (adr_i == `FHP_OFS_CMD && sel_i[0] && !r_reg.lowPower) begin
        unique case (op)
          `FHP_OP_SPECIFY: begin
            r_next.step_rate_time = dat_i[11:8];
          end
          `FHP_OP_SEEK: begin
            if (!driveActive[drv] && !r_reg.ridActive) begin
              r_next.tgt = dat_i[15:8];
              r_next.startSeek[drv] = 1'b1;
            end
          end
          `FHP_OP_RECAL: begin
            if (!driveActive[drv] && !r_reg.ridActive) begin
              r_next.startRecal[drv] = 1'b1;
            end
          end
          `FHP_OP_READ_ID: begin
            if (!r_reg.ridActive) begin
              r_next.ridActive = 1'b1;
              r_next.ridIxCnt = 2'h0;
              r_next.ridDrive = drv;
              r_next.ridHead = dat_i[6];
            end
          end
          `FHP_OP_SENSE: begin
            if (|r_reg.intPend) begin
              r_next.senseSt0 = r_reg.driveSt0[pick];
              r_next.sensePcn = presentCyl[pick];
              r_next.intPend[pick] = 1'b0;
            end else begin
              r_next.senseSt0 = {`FHP_IC_INVALID, 6'h00};
              r_next.sensePcn = 8'h00;
            end
          end
          default: begin
          end
        endcase
      end
      if (adr_i == `FHP_OFS_CONFIG) begin
        if (sel_i[0]) begin
          r_next.step_rate_time = dat_i[3:0];
          r_next.lowPower = dat_i[4];
          if (r_reg.lowPower && !dat_i[4]) begin
            r_next.clearPos = 1'b1;
            r_next.driveSt0 = '0;
            r_next.senseSt0 = 8'h00;
            r_next.sensePcn = 8'h00;
            r_next.ridSt0 = 8'h00;
            r_next.ridSt1 = 8'h00;
          end
        end
        if (sel_i[1]) begin
          r_next.gap = dat_i[15:8];
        end
      end
      if (adr_i == `FHP_OFS_FMT && sel_i[0]) begin
        r_next.fmtIdx = dat_i[3:0];
      end
    end

    if (hit && !we_i) begin
      unique case (adr_i)
        `FHP_OFS_CMD,
        `FHP_OFS_STATUS: r_next.datOut = {19'h00000, r_reg.lowPower, r_reg.intPend, driveActive, 2'h0,
                                           r_reg.irq, r_reg.ridActive};
        `FHP_OFS_RESULT: r_next.datOut = {16'h0000, r_reg.sensePcn, r_reg.senseSt0};
        `FHP_OFS_ID: begin
          r_next.datOut = {r_reg.idN, r_reg.idR, r_reg.idH, r_reg.idC};
          r_next.ridIrq = 1'b0;
        end
        `FHP_OFS_IDSTAT: r_next.datOut = {16'h0000, r_reg.ridSt1, r_reg.ridSt0};
        `FHP_OFS_CONFIG: r_next.datOut = {16'h0000, r_reg.gap, 3'h0, r_reg.lowPower, r_reg.step_rate_time};
        `FHP_OFS_FMT: r_next.datOut = {8'h00, fmt, 4'h0, r_reg.fmtIdx};
        `FHP_OFS_PCN: r_next.datOut = {presentCyl[3], presentCyl[2], presentCyl[1], presentCyl[0]};
        default: r_next.datOut = 32'h00000000;
      endcase
    end

    // completion events come after the clears so a same-cycle set wins
    for (int d = 0; d < 4; d++) begin
      if (doneStrobe[d]) begin
        r_next.driveSt0[d] = {`FHP_IC_NORMAL, 1'b1, equipFault[d], 1'b0, 1'b0, 2'(d)};
        r_next.intPend[d] = 1'b1;
      end
    end

    if (r_reg.ridActive) begin
      if (idValid) begin
        r_next.idC = idCyl;
        r_next.idH = idHead;
        r_next.idR = idSector;
        r_next.idN = idSize;
        r_next.ridSt0 = {`FHP_IC_NORMAL, 3'h0, r_reg.ridHead, r_reg.ridDrive};
        r_next.ridSt1 = 8'h00;
        r_next.ridActive = 1'b0;
        r_next.ridIrq = 1'b1;
      end else if (r_next.ixLvl && !r_reg.ixLvl) begin
        if (r_reg.ridIxCnt == `FHP_INDEX_LIMIT - 2'h1) begin
          r_next.ridSt0 = {`FHP_IC_ABNORMAL, 3'h0, r_reg.ridHead, r_reg.ridDrive};
          r_next.ridSt1 = `FHP_ST1_MARK_ABSENT;
          r_next.ridActive = 1'b0;
          r_next.ridIrq = 1'b1;
        end else begin
          r_next.ridIxCnt = r_reg.ridIxCnt + 2'h1;
        end
      end
    end

    r_next.irq = (|r_next.intPend) | r_next.ridIrq;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      r_reg <= '{step_rate_time: `FHP_SRT_RST, gap: `FHP_GAP_RST, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // one positioner per drive so all four can step at once
  for (genvar g = 0; g < 4; g++) begin : gDrive
    fhp_drive_pos #(
      .STEP_UNIT_CYC(STEP_UNIT_CYC)
    ) uDrive (
      .mclk(mclk),
      .rst(rst),
      .startSeek(r_reg.startSeek[g]),
      .startRecal(r_reg.startRecal[g]),
      .targetCyl(r_reg.tgt),
      .stepRate(r_reg.step_rate_time),
      .trackZero(r_reg.tzLvl[g]),
      .clearPos(r_reg.clearPos),
      .presentCyl(presentCyl[g]),
      .doneStrobe(doneStrobe[g]),
      .equipFault(equipFault[g]),
      .active(driveActive[g]),
      .stepOut(stepOut[g]),
      .dirOut(dirOut[g])
    );
  end

  assign dat_o = r_reg.datOut;
  assign ack_o = r_reg.ack;
  assign fdcIrq = r_reg.irq;

endmodule

//--- verilog/fhp_map.svh
`ifndef FHP_MAP_SVH
`define FHP_MAP_SVH

// timing
`define FHP_CLK_PERIOD_NS 4
`define FHP_STEP_UNIT_NS 1000000
`define FHP_STEP_PULSE_NS 1000
`define FHP_STEP_PULSE_CYC ((`FHP_STEP_PULSE_NS + `FHP_CLK_PERIOD_NS - 1) / `FHP_CLK_PERIOD_NS)
`define FHP_SRT_BASE 5'h10
`define FHP_RECAL_MAX_STEPS 7'h4f
`define FHP_INDEX_LIMIT 2'h2

// register byte offsets
`define FHP_OFS_CMD 8'h00
`define FHP_OFS_STATUS 8'h04
`define FHP_OFS_RESULT 8'h08
`define FHP_OFS_ID 8'h0c
`define FHP_OFS_IDSTAT 8'h10
`define FHP_OFS_CONFIG 8'h14
`define FHP_OFS_FMT 8'h18
`define FHP_OFS_PCN 8'h1c

// command opcodes
`define FHP_OP_SPECIFY 4'h3
`define FHP_OP_RECAL 4'h7
`define FHP_OP_SENSE 4'h8
`define FHP_OP_READ_ID 4'ha
`define FHP_OP_SEEK 4'hf

// interrupt codes and status bits
`define FHP_IC_NORMAL 2'h0
`define FHP_IC_ABNORMAL 2'h1
`define FHP_IC_INVALID 2'h2
`define FHP_ST1_MARK_ABSENT 8'h01

// reset values
`define FHP_SRT_RST 4'h8
`define FHP_GAP_RST 8'h1b

`endif

//--- verilog/fhp_pkg.sv
package fhp_pkg;

  typedef enum logic [2:0] {
    FHP_DRV_IDLE = 3'b001,
    FHP_DRV_CHECK = 3'b010,
    FHP_DRV_STEP = 3'b100
  } fhp_drv_state_t;

  typedef struct packed {
    fhp_drv_state_t state;
    logic [7:0] present_cylinder;
    logic [7:0] target_cylinder;
    logic recal;
    logic [6:0] steps;
    logic [19:0] unitCnt;
    logic [4:0] unitsLeft;
    logic [8:0] pulseCnt;
    logic done;
    logic eqc;
    logic step;
    logic dir;
  } fhp_drv_regs_t;

  typedef struct packed {
    logic ack;
    logic [31:0] datOut;
    logic [3:0] tzS1;
    logic [3:0] tzS2;
    logic [3:0] tzS3;
    logic [3:0] tzLvl;
    logic ixS1;
    logic ixS2;
    logic ixS3;
    logic ixLvl;
    logic [3:0] step_rate_time;
    logic lowPower;
    logic clearPos;
    logic [7:0] gap;
    logic [3:0] fmtIdx;
    logic [7:0] tgt;
    logic [3:0] startSeek;
    logic [3:0] startRecal;
    logic [3:0][7:0] driveSt0;
    logic [3:0] intPend;
    logic [7:0] senseSt0;
    logic [7:0] sensePcn;
    logic ridActive;
    logic [1:0] ridIxCnt;
    logic ridIrq;
    logic [1:0] ridDrive;
    logic ridHead;
    logic [7:0] idC;
    logic [7:0] idH;
    logic [7:0] idR;
    logic [7:0] idN;
    logic [7:0] ridSt0;
    logic [7:0] ridSt1;
    logic irq;
  } fhp_top_regs_t;

endpackage

//--- verilog/fhp_drive_pos.sv
`timescale 1ns/10ps
`include "fhp_map.svh"

module fhp_drive_pos #(
  parameter int STEP_UNIT_CYC = 250000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic startSeek,
  input wire logic startRecal,
  input wire logic [7:0] targetCyl,
  input wire logic [3:0] stepRate,
  input wire logic trackZero,
  input wire logic clearPos,
  output logic [7:0] presentCyl,
  output logic doneStrobe,
  output logic equipFault,
  output logic active,
  output logic stepOut,
  output logic dirOut
);

  fhp_pkg::fhp_drv_regs_t r_reg;
  fhp_pkg::fhp_drv_regs_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (clearPos) begin
      r_next.present_cylinder = 8'h00;
    end
    unique case (r_reg.state)
      fhp_pkg::FHP_DRV_IDLE: begin
        if (startRecal) begin
          r_next.recal = 1'b1;
          r_next.present_cylinder = 8'h00;
          r_next.steps = 7'h00;
          r_next.eqc = 1'b0;
          r_next.state = fhp_pkg::FHP_DRV_CHECK;
        end else if (startSeek) begin
          r_next.recal = 1'b0;
          r_next.target_cylinder = targetCyl;
          r_next.eqc = 1'b0;
          r_next.state = fhp_pkg::FHP_DRV_CHECK;
        end
      end
      fhp_pkg::FHP_DRV_CHECK: begin
        r_next.state = fhp_pkg::FHP_DRV_STEP;
        r_next.step = 1'b1;
        r_next.pulseCnt = 9'(`FHP_STEP_PULSE_CYC - 1);
        r_next.unitCnt = 20'(STEP_UNIT_CYC - 1);
        r_next.unitsLeft = `FHP_SRT_BASE - {1'b0, stepRate};
        if (r_reg.recal) begin
          r_next.dir = 1'b0;
          if (trackZero) begin
            r_next.step = 1'b0;
            r_next.done = 1'b1;
            r_next.state = fhp_pkg::FHP_DRV_IDLE;
          end else if (r_reg.steps == `FHP_RECAL_MAX_STEPS) begin
            r_next.step = 1'b0;
            r_next.done = 1'b1;
            r_next.eqc = 1'b1;
            r_next.state = fhp_pkg::FHP_DRV_IDLE;
          end
        end else if (r_reg.present_cylinder == r_reg.target_cylinder) begin
          r_next.step = 1'b0;
          r_next.done = 1'b1;
          r_next.state = fhp_pkg::FHP_DRV_IDLE;
        end else begin
          r_next.dir = (r_reg.present_cylinder < r_reg.target_cylinder);
        end
      end
      fhp_pkg::FHP_DRV_STEP: begin
        if (r_reg.pulseCnt != 9'h000) begin
          r_next.pulseCnt = r_reg.pulseCnt - 9'h001;
        end else begin
          r_next.step = 1'b0;
        end
        // interval runs from the pulse's leading edge, so pulse width is part of it
        if (r_reg.unitCnt != 20'h00000) begin
          r_next.unitCnt = r_reg.unitCnt - 20'h00001;
        end else begin
          r_next.unitCnt = 20'(STEP_UNIT_CYC - 1);
          r_next.unitsLeft = r_reg.unitsLeft - 5'h01;
          if (r_reg.unitsLeft <= 5'h01) begin
            r_next.step = 1'b0;
            r_next.state = fhp_pkg::FHP_DRV_CHECK;
            if (r_reg.recal) begin
              r_next.steps = r_reg.steps + 7'h01;
            end else if (r_reg.dir) begin
              r_next.present_cylinder = r_reg.present_cylinder + 8'h01;
            end else begin
              r_next.present_cylinder = r_reg.present_cylinder - 8'h01;
            end
          end
        end
      end
      default: begin
        r_next.state = fhp_pkg::FHP_DRV_IDLE;
        r_next.step = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      r_reg <= '{state: fhp_pkg::FHP_DRV_IDLE, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign presentCyl = r_reg.present_cylinder;
  assign doneStrobe = r_reg.done;
  assign equipFault = r_reg.eqc;
  assign active = (r_reg.state != fhp_pkg::FHP_DRV_IDLE);
  assign stepOut = r_reg.step;
  assign dirOut = r_reg.dir;

endmodule

//--- dv/fhp_top_props.sv
`timescale 1ns/10ps
module fhp_top_props #(
  parameter int STEP_UNIT_CYC = 20
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [3:0] trackZeroIn,
  input wire logic [3:0] stepOut,
  input wire logic [3:0] dirOut,
  input wire logic fdcIrq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // cycles since last drive 0 step, saturates so the first step passes
  logic [11:0] gapCnt;
  always_ff @(posedge mclk) begin
    if (rst) gapCnt <= 12'hfff;
    else if ($rose(stepOut[0])) gapCnt <= 12'h000;
    else if (gapCnt != 12'hfff) gapCnt <= gapCnt + 12'h001;
  end
  a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered next cycle");
  a_ack_one_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_step_min_width: assert property ($rose(stepOut[0]) |-> stepOut[0] [*8])
    else $error("step pulse too short");
  a_step_spacing: assert property ($rose(stepOut[0]) |-> gapCnt >= STEP_UNIT_CYC - 1)
    else $error("step pulses closer than step rate");
  a_dir_steady_step: assert property (stepOut[0] && $past(stepOut[0]) |-> $stable(dirOut[0]))
    else $error("direction changed during step");
  a_recal_stop_zero: assert property ($rose(stepOut[2]) && !dirOut[2] |-> !$past(trackZeroIn[2], 8))
    else $error("step out issued at track zero");
  a_read_data_hold: assert property ($changed(dat_o) |-> ack_o && !we_i)
    else $error("read data changed without a read");
  a_irq_drop_cause: assert property ($fell(fdcIrq) |-> ack_o || $past(ack_o) || $past(ack_o, 2))
    else $error("interrupt dropped without host access");
  cover property ($rose(fdcIrq));
  cover property ($rose(stepOut[3]));
  cover property (ack_o && we_i);
endmodule

//--- dv/fhp_drive_model.sv
`timescale 1ns/10ps
module fhp_drive_model (
  input wire logic mclk,
  input wire logic [3:0] stepOut,
  input wire logic [3:0] dirOut,
  input wire logic idOn,
  output logic [3:0] trackZeroIn,
  output logic indexPulseIn,
  output logic idValid,
  output logic [7:0] idCyl,
  output logic [7:0] idHead,
  output logic [7:0] idSector,
  output logic [7:0] idSize,
  output logic [3:0][7:0] headPos
);
  logic [3:0] stepPrev = 4'h0;
  logic [7:0] rotCnt = 8'h00;
  // heads are mechanical: they keep position across controller reset
  initial headPos = {8'h5a, 8'h06, 8'h00, 8'h00};
  always @(posedge mclk) begin
    stepPrev <= stepOut;
    rotCnt <= (rotCnt == 8'hc7) ? 8'h00 : rotCnt + 8'h01;
    for (int d = 0; d < 4; d++) begin
      if (stepOut[d] && !stepPrev[d]) begin
        if (dirOut[d]) headPos[d] <= headPos[d] + 8'h01;
        else if (headPos[d] != 8'h00) headPos[d] <= headPos[d] - 8'h01;
      end
    end
  end
  assign trackZeroIn = {headPos[3] == 8'h00, headPos[2] == 8'h00, headPos[1] == 8'h00, headPos[0] == 8'h00};
  assign indexPulseIn = rotCnt < 8'h0a;
  assign idValid = idOn && rotCnt == 8'h64;
  // outside the valid cycle the id lines show inverted junk
  assign idCyl = idValid ? headPos[0] : ~headPos[0];
  assign idHead = idValid ? 8'h01 : 8'hfe;
  assign idSector = idValid ? 8'h07 : 8'hf8;
  assign idSize = idValid ? 8'h02 : 8'hfd;
endmodule

//--- dv/test_floppy_head_positioning.sv
`timescale 1ns/10ps
module test_floppy_head_positioning;
  localparam int UNIT = 20;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic idOn = 1'b0;
  logic [31:0] rdat, datOut;
  logic ackOut, idValid, indexPulseIn, fdcIrq;
  logic [3:0] trackZeroIn, stepOut, dirOut;
  logic [7:0] idCyl, idHead, idSector, idSize;
  logic [3:0][7:0] headPos;
  int error_cnt = 0;
  int checks = 0;
  fhp_top #(.STEP_UNIT_CYC(UNIT)) i_fhp_top (.mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(datOut), .ack_o(ackOut), .trackZeroIn(trackZeroIn),
    .indexPulseIn(indexPulseIn), .idValid(idValid), .idCyl(idCyl), .idHead(idHead), .idSector(idSector),
    .idSize(idSize), .stepOut(stepOut), .dirOut(dirOut), .fdcIrq(fdcIrq));
  fhp_drive_model i_fhp_drive_model (.mclk(mclk), .stepOut(stepOut), .dirOut(dirOut), .idOn(idOn),
    .trackZeroIn(trackZeroIn), .indexPulseIn(indexPulseIn), .idValid(idValid), .idCyl(idCyl),
    .idHead(idHead), .idSector(idSector), .idSize(idSize), .headPos(headPos));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ackOut !== 1'b1 && n < 50);
    rdat = datOut;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) chk("bus ack", 32'h1, 32'h0);
    @(posedge mclk);
  endtask
  function automatic logic [31:0] cmd(input logic [3:0] op, input logic [1:0] drv, input logic hd,
    input logic [7:0] arg);
    return {16'h0000, arg, 1'b0, hd, drv, op};
  endfunction
  task automatic wait_irq;
    int n;
    n = 0;
    while (fdcIrq !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 5000) chk("irq wait", 32'h1, 32'h0);
  endtask
  task automatic sense(input logic [31:0] exp);
    wb(1'b1, 8'h00, cmd(4'h8, 2'h0, 1'b0, 8'h00));
    wb(1'b0, 8'h08, 32'h0);
    chk("sense result", exp, rdat);
  endtask
  // head bit is requested on purpose; status must still report head 0
  task automatic seek_to(input logic [7:0] tgt, input logic dir);
    wb(1'b1, 8'h00, cmd(4'hf, 2'h0, 1'b1, tgt));
    repeat (4) @(posedge mclk);
    chk("seek direction", {31'h0, dir}, {31'h0, dirOut[0]});
    wait_irq();
    chk("head position", {24'h0, tgt}, {24'h0, headPos[0]});
    sense({16'h0000, tgt, 8'h20});
    chk("irq after sense", 32'h0, {31'h0, fdcIrq});
  endtask
  task automatic t_config;
    wb(1'b1, 8'h00, cmd(4'h3, 2'h0, 1'b0, 8'h0f));
    repeat (10) @(posedge mclk);
    chk("irq after specify", 32'h0, {31'h0, fdcIrq});
    wb(1'b1, 8'h14, 32'h0000_540f);
    wb(1'b0, 8'h14, 32'h0);
    chk("config readback", 32'h0000_540f, rdat);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped read", 32'h0, rdat);
    $display("config test done");
  endtask
  task automatic t_seek;
    seek_to(8'h05, 1'b1);
    seek_to(8'h02, 1'b0);
    $display("seek test done");
  endtask
  task automatic t_recal;
    wb(1'b1, 8'h00, cmd(4'h7, 2'h2, 1'b0, 8'h00));
    wb(1'b1, 8'h00, cmd(4'h7, 2'h3, 1'b0, 8'h00));
    repeat (6) @(posedge mclk);
    wb(1'b0, 8'h04, 32'h0);
    chk("drives active", 32'h0000_000c, {28'h0, rdat[7:4]});
    chk("recal direction", 32'h0, {30'h0, dirOut[3:2]});
    wait_irq();
    sense(32'h0000_0022);
    chk("recal head two", 32'h0, {24'h0, headPos[2]});
    wait_irq();
    sense(32'h0000_0033);
    chk("recal step count", 32'h0000_000b, {24'h0, headPos[3]});
    $display("recal test done");
  endtask
  task automatic t_read_id;
    idOn <= 1'b1;
    wb(1'b1, 8'h00, cmd(4'ha, 2'h0, 1'b0, 8'h00));
    wait_irq();
    wb(1'b0, 8'h0c, 32'h0);
    chk("id fields", 32'h0207_0102, rdat);
    idOn <= 1'b0;
    wb(1'b1, 8'h00, cmd(4'ha, 2'h0, 1'b0, 8'h00));
    wait_irq();
    wb(1'b0, 8'h10, 32'h0);
    chk("id missing status", 32'h0000_0140, rdat);
    wb(1'b0, 8'h0c, 32'h0);
    chk("irq after id read", 32'h0, {31'h0, fdcIrq});
    $display("read id test done");
  endtask
  task automatic t_low_power;
    wb(1'b1, 8'h14, 32'h0000_541f);
    wb(1'b1, 8'h00, cmd(4'hf, 2'h0, 1'b0, 8'h09));
    repeat (40) @(posedge mclk);
    chk("seek in low power", 32'h0000_0002, {24'h0, headPos[0]});
    wb(1'b1, 8'h14, 32'h0000_540f);
    wb(1'b0, 8'h1c, 32'h0);
    chk("cylinders cleared", 32'h0, rdat);
    wb(1'b0, 8'h08, 32'h0);
    chk("sense result cleared", 32'h0, rdat);
    sense(32'h0000_0080);
    $display("low power test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_config();
    t_seek();
    t_recal();
    t_read_id();
    t_low_power();
    wrap_up();
  end
  // whole run needs about 2300 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    wrap_up();
  end
endmodule
bind fhp_top fhp_top_props #(.STEP_UNIT_CYC(STEP_UNIT_CYC)) i_fhp_top_props (.mclk(mclk), .rst(rst),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .trackZeroIn(trackZeroIn),
  .stepOut(stepOut), .dirOut(dirOut), .fdcIrq(fdcIrq));
